/* verilog/rsflg_params.svh */
// Register offsets, field positions, reset values and counts of the reset state and flag logic.
`ifndef RSFLG_PARAMS_SVH
`define RSFLG_PARAMS_SVH

`define RSFLG_OFS_STATUS     8'h00
`define RSFLG_OFS_INT_EN     8'h04
`define RSFLG_OFS_TIMER_EN   8'h08
`define RSFLG_OFS_PORT_DIR   8'h0C
`define RSFLG_OFS_WDT_CTRL   8'h10
`define RSFLG_OFS_WDT_COUNT  8'h14
`define RSFLG_OFS_IRQ_STAT   8'h18
`define RSFLG_OFS_IRQ_MASK   8'h1C

`define RSFLG_ST_TIMEOUT     0
`define RSFLG_ST_PDOWN       1
`define RSFLG_ST_LOW_VOLTAGE_RESET_FLAG        2
`define RSFLG_ST_CAUSE_LO    4
`define RSFLG_ST_CAUSE_HI    7
`define RSFLG_ST_CORE_RST    8

`define RSFLG_WDT_EN_BIT     0
`define RSFLG_WDT_KICK_BIT   1

`define RSFLG_EV_LVR         0
`define RSFLG_EV_EXT         1
`define RSFLG_EV_WDT_RUN     2
`define RSFLG_EV_WDT_SLEEP   3
`define RSFLG_EV_N           4

`define RSFLG_CAUSE_POR      4'h1
`define RSFLG_WDT_TIMEOUT    16'hFFFF
`define RSFLG_HSIZE_WORD     3'h2

`endif

/* verilog/rsflg_pkg.sv */
// Types shared by the reset state and flag logic.
package rsflg_pkg;

   typedef enum logic [1:0] {
      RSFLG_MODE_NORMAL,
      RSFLG_MODE_SLOW,
      RSFLG_MODE_IDLE,
      RSFLG_MODE_SLEEP
   } rsflg_mode_t;

   typedef enum logic [1:0] {
      RSFLG_RUN,
      RSFLG_HOLD,
      RSFLG_APPLY
   } rsflg_state_t;

endpackage

/* verilog/rsflg_sync.sv */
// Two-flop synchroniser for asynchronous pin levels, one stage pair per bit.
`timescale 1ns/1ps
`default_nettype none

module rsflg_sync
#(
   parameter int              W       = 1,
   parameter logic [W-1:0]    RST_VAL = '0
)
(
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          ce,
   input  wire logic [W-1:0]  d,
   output logic      [W-1:0]  q
);

   logic [W-1:0] meta;

   genvar i;
   generate
      for (i = 0; i < W; i = i + 1)
      begin : g_bit
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               meta[i] <= RST_VAL[i];
               q[i]    <= RST_VAL[i];
            end
            else if (ce)
            begin
               meta[i] <= d[i];
               q[i]    <= meta[i];
            end
         end
      end
   endgenerate

endmodule

`default_nettype wire

/* verilog/rsflg_top.sv */
// Reset state and flag logic with an AHB-Lite register slave and a small watchdog.
//
// Functional notes
// RULE_01 - Time-out and power-down flags live in the status register and power-on reset clears both.
// RULE_02 - A supply monitor reset in normal or slow mode leaves both flags unchanged.
// RULE_03 - A watchdog reset in normal or slow mode sets the time-out flag and keeps power-down.
// RULE_04 - A watchdog reset in idle or sleep mode sets both the time-out and power-down flags.
// RULE_05 - Power-on reset disables every interrupt enable.
// RULE_06 - Power-on reset clears the watchdog and time bases and the watchdog counts again at once.
// RULE_07 - Power-on reset switches every timer module off.
// RULE_08 - Power-on reset sets every port direction control to input.
// RULE_09 - Power-on reset loads the stack pointer with the top of the stack.
// RULE_10 - Every reset, the external pin included, sends the program counter back to zero.
// RULE_11 - A watchdog reset in sleep or idle clears only program counter and stack pointer.
// RULE_12 - A supply monitor reset sets the low-voltage flag, which software can clear but not set.
// RULE_13 - Other resets leave both flags unchanged, and the cause is sampled at reset release.
//
// The placing of the registers and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "rsflg_params.svh"

module rsflg_top
   import rsflg_pkg::*;
#(
   parameter int             N_TIMERS    = 2,
   parameter int             N_PINS      = 8,
   parameter int             N_INTS      = 8,
   parameter logic [15:0]    WDT_TIMEOUT = `RSFLG_WDT_TIMEOUT
)
(
   input  wire logic                hclk,
   input  wire logic                hresetn,
   input  wire logic                ce,
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic      [31:0]         hrdata,
   output logic                     hreadyout,
   output logic                     hresp,
   input  wire logic                ext_reset_n_pin,
   input  wire logic                supply_monitor_reset,
   input  wire rsflg_mode_t         cpu_mode,
   input  wire logic                halt_entry,
   output logic                     core_reset,
   output logic                     pc_clear,
   output logic                     sp_load_top,
   output logic                     sp_clear,
   output logic      [N_INTS-1:0]   int_enable,
   output logic      [N_TIMERS-1:0] timer_enable,
   output logic      [N_PINS-1:0]   port_dir_input,
   output logic                     timeout_flag,
   output logic                     power_down_flag,
   output logic                     low_voltage_reset_flag,
   output logic                     irq
);

   // Synchronised pin levels.
   logic [1:0]               pins_sync;
   logic                     ext_req;
   logic                     lvr_req;
   logic                     wdt_fire_reg;
   logic                     any_req;
   logic                     sleeping;

   rsflg_state_t             state_reg;
   logic                     seen_lvr_reg;
   logic                     seen_ext_reg;
   logic                     seen_wdt_reg;
   logic                     rel_sleep_reg;

   logic                     apply;
   logic                     wdt_only;
   logic                     full_reset;
   logic                     warm_reset;

   logic [15:0]              wdt_count_reg;
   logic                     wdt_en_reg;
   logic [3:0]               cause_reg;
   logic [`RSFLG_EV_N-1:0]   irq_stat_reg;
   logic [`RSFLG_EV_N-1:0]   irq_mask_reg;
   logic [`RSFLG_EV_N-1:0]   events;

   logic                     dp_valid_reg;
   logic                     dp_write_reg;
   logic                     dp_word_reg;
   logic [7:0]               dp_addr_reg;
   logic                     wr_en;
   logic [31:0]              rd_mux;

   rsflg_sync
   #(
      .W       (2),
      .RST_VAL (2'h1)
   )
   u_sync
   (
      .clk   (hclk),
      .rst_n (hresetn),
      .ce    (ce),
      .d     ({supply_monitor_reset, ext_reset_n_pin}),
      .q     (pins_sync)
   );

   assign sleeping = (cpu_mode == RSFLG_MODE_IDLE) || (cpu_mode == RSFLG_MODE_SLEEP);
   assign ext_req  = ~pins_sync[0];
   // The supply monitor is switched off in idle and sleep, so its request is ignored there.
   assign lvr_req  = pins_sync[1] & ~sleeping;
   assign any_req  = ext_req | lvr_req | wdt_fire_reg;

   // Sequencer: hold the core in reset while any source asserts, decide on release.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         // Power-on enters the hold state with no cause seen, so release applies a full reset.
         state_reg     <= RSFLG_HOLD;
         seen_lvr_reg  <= 1'b0;
         seen_ext_reg  <= 1'b0;
         seen_wdt_reg  <= 1'b0;
         rel_sleep_reg <= 1'b0;
      end
      else if (ce)
      begin
         case (state_reg)
            RSFLG_RUN:
            begin
               if (any_req)
               begin
                  state_reg    <= RSFLG_HOLD;
                  seen_lvr_reg <= lvr_req;
                  seen_ext_reg <= ext_req;
                  seen_wdt_reg <= wdt_fire_reg;
               end
            end
            RSFLG_HOLD:
            begin
               seen_lvr_reg <= seen_lvr_reg | lvr_req;
               seen_ext_reg <= seen_ext_reg | ext_req;
               seen_wdt_reg <= seen_wdt_reg | wdt_fire_reg;
               if (!any_req)
               begin
                  state_reg     <= RSFLG_APPLY;
                  rel_sleep_reg <= sleeping; // RULE_13
               end
            end
            RSFLG_APPLY:
            begin
               state_reg <= RSFLG_RUN;
            end
            default:
            begin
               state_reg <= RSFLG_RUN;
            end
         endcase
      end
   end

   assign apply      = ce && (state_reg == RSFLG_APPLY);
   assign wdt_only   = seen_wdt_reg & ~seen_lvr_reg & ~seen_ext_reg;
   assign warm_reset = apply & wdt_only & rel_sleep_reg;
   // Power-on, supply monitor, pin and running-mode watchdog resets all restore the full state.
   assign full_reset = apply & ~(wdt_only & rel_sleep_reg);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         core_reset  <= 1'b1;
         pc_clear    <= 1'b0;
         sp_load_top <= 1'b0;
         sp_clear    <= 1'b0;
      end
      else if (ce)
      begin
         core_reset  <= (state_reg == RSFLG_RUN) ? any_req : (state_reg == RSFLG_HOLD);
         pc_clear    <= apply; // RULE_10
         sp_load_top <= full_reset; // RULE_09
         sp_clear    <= warm_reset; // RULE_11
      end
   end

   // Time-out and power-down flags.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         timeout_flag    <= 1'b0; // RULE_01
         power_down_flag <= 1'b0; // RULE_01
      end
      else if (ce)
      begin
         // Supply monitor and pin resets fall through and keep both flags.
         if (apply && wdt_only) // RULE_02
         begin
            timeout_flag <= 1'b1; // RULE_03
         end
         if (warm_reset || (halt_entry && state_reg == RSFLG_RUN))
         begin
            power_down_flag <= 1'b1; // RULE_04
         end
      end
   end

   // Low-voltage flag: the hardware set wins over a software clear in the same cycle.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         low_voltage_reset_flag <= 1'b0;
      end
      else if (ce)
      begin
         if (apply && seen_lvr_reg)
         begin
            low_voltage_reset_flag <= 1'b1; // RULE_12
         end
         else if (wr_en && dp_addr_reg == `RSFLG_OFS_STATUS && hwdata[`RSFLG_ST_LOW_VOLTAGE_RESET_FLAG])
         begin
            low_voltage_reset_flag <= 1'b0; // RULE_12
         end
      end
   end

   // Last cause, one bit per source with power-on in bit 0.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cause_reg <= `RSFLG_CAUSE_POR;
      end
      else if (ce && apply)
      begin
         cause_reg <= {seen_wdt_reg, seen_ext_reg, seen_lvr_reg,
                       ~(seen_wdt_reg | seen_ext_reg | seen_lvr_reg)};
      end
   end

   // Core-side controls restored by a full reset.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         int_enable     <= '0;
         timer_enable   <= '0;
         port_dir_input <= '1;
      end
      else if (ce)
      begin
         if (full_reset)
         begin
            int_enable     <= '0; // RULE_05
            timer_enable   <= '0; // RULE_07
            port_dir_input <= '1; // RULE_08
         end
         else if (wr_en)
         begin
            if (dp_addr_reg == `RSFLG_OFS_INT_EN)
            begin
               int_enable <= hwdata[N_INTS-1:0];
            end
            else if (dp_addr_reg == `RSFLG_OFS_TIMER_EN)
            begin
               timer_enable <= hwdata[N_TIMERS-1:0];
            end
            else if (dp_addr_reg == `RSFLG_OFS_PORT_DIR)
            begin
               port_dir_input <= hwdata[N_PINS-1:0];
            end
         end
      end
   end

   // Watchdog and time base counter. It keeps running in sleep so it can wake the core.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wdt_count_reg <= 16'h0000;
         wdt_en_reg    <= 1'b1;
         wdt_fire_reg  <= 1'b0;
      end
      else if (ce)
      begin
         wdt_fire_reg <= 1'b0;
         if (full_reset)
         begin
            wdt_count_reg <= 16'h0000; // RULE_06
            wdt_en_reg    <= 1'b1; // RULE_06
         end
         else if (wr_en && dp_addr_reg == `RSFLG_OFS_WDT_CTRL)
         begin
            wdt_en_reg <= hwdata[`RSFLG_WDT_EN_BIT];
            if (hwdata[`RSFLG_WDT_KICK_BIT])
            begin
               wdt_count_reg <= 16'h0000;
            end
         end
         else if (wdt_en_reg && !core_reset)
         begin
            if (wdt_count_reg >= WDT_TIMEOUT)
            begin
               wdt_count_reg <= 16'h0000;
               wdt_fire_reg  <= 1'b1;
            end
            else
            begin
               wdt_count_reg <= wdt_count_reg + 16'h0001;
            end
         end
      end
   end

   // Interrupt status: set wins over the write-one clear.
   assign events = {warm_reset,
                    apply & wdt_only & ~rel_sleep_reg,
                    apply & seen_ext_reg,
                    apply & seen_lvr_reg};

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         irq_stat_reg <= '0;
         irq_mask_reg <= '0;
         irq          <= 1'b0;
      end
      else if (ce)
      begin
         if (wr_en && dp_addr_reg == `RSFLG_OFS_IRQ_STAT)
         begin
            irq_stat_reg <= (irq_stat_reg & ~hwdata[`RSFLG_EV_N-1:0]) | events;
         end
         else
         begin
            irq_stat_reg <= irq_stat_reg | events;
         end
         if (wr_en && dp_addr_reg == `RSFLG_OFS_IRQ_MASK)
         begin
            irq_mask_reg <= hwdata[`RSFLG_EV_N-1:0];
         end
         irq <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // AHB-Lite address phase capture. Reads take one wait state so data comes from a flop.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_valid_reg <= 1'b0;
         dp_write_reg <= 1'b0;
         dp_word_reg  <= 1'b0;
         dp_addr_reg  <= 8'h00;
         hreadyout    <= 1'b1;
         hresp        <= 1'b0;
      end
      else if (ce)
      begin
         if (hready)
         begin
            dp_valid_reg <= hsel & htrans[1];
            dp_write_reg <= hwrite;
            dp_word_reg  <= (hsize == `RSFLG_HSIZE_WORD);
            dp_addr_reg  <= haddr[7:0];
            hreadyout    <= ~(hsel & htrans[1] & ~hwrite);
         end
         else
         begin
            hreadyout <= 1'b1;
         end
      end
   end

   assign wr_en = ce & dp_valid_reg & dp_write_reg & dp_word_reg & hready;

   always_comb
   begin
      rd_mux = 32'h0000_0000;
      if (dp_addr_reg == `RSFLG_OFS_STATUS)
      begin
         rd_mux[`RSFLG_ST_TIMEOUT]                     = timeout_flag;
         rd_mux[`RSFLG_ST_PDOWN]                       = power_down_flag;
         rd_mux[`RSFLG_ST_LOW_VOLTAGE_RESET_FLAG]                        = low_voltage_reset_flag;
         rd_mux[`RSFLG_ST_CAUSE_HI:`RSFLG_ST_CAUSE_LO] = cause_reg;
         rd_mux[`RSFLG_ST_CORE_RST]                    = core_reset;
      end
      else if (dp_addr_reg == `RSFLG_OFS_INT_EN)
      begin
         rd_mux[N_INTS-1:0] = int_enable;
      end
      else if (dp_addr_reg == `RSFLG_OFS_TIMER_EN)
      begin
         rd_mux[N_TIMERS-1:0] = timer_enable;
      end
      else if (dp_addr_reg == `RSFLG_OFS_PORT_DIR)
      begin
         rd_mux[N_PINS-1:0] = port_dir_input;
      end
      else if (dp_addr_reg == `RSFLG_OFS_WDT_CTRL)
      begin
         rd_mux[`RSFLG_WDT_EN_BIT] = wdt_en_reg;
      end
      else if (dp_addr_reg == `RSFLG_OFS_WDT_COUNT)
      begin
         rd_mux[15:0] = wdt_count_reg;
      end
      else if (dp_addr_reg == `RSFLG_OFS_IRQ_STAT)
      begin
         rd_mux[`RSFLG_EV_N-1:0] = irq_stat_reg;
      end
      else if (dp_addr_reg == `RSFLG_OFS_IRQ_MASK)
      begin
         rd_mux[`RSFLG_EV_N-1:0] = irq_mask_reg;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata <= 32'h0000_0000;
      end
      else if (ce && !hreadyout)
      begin
         hrdata <= rd_mux;
      end
   end

endmodule

`default_nettype wire

/* tb/rsflg_top_sva.sv */
// Port-level assertions for the reset state and flag logic.
`timescale 1ns/1ps
`default_nettype none

module rsflg_top_sva
#(
   parameter int N_TIMERS = 2,
   parameter int N_PINS   = 8,
   parameter int N_INTS   = 8
)
(
   input  wire logic                hclk,
   input  wire logic                hresetn,
   input  wire logic                hsel,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic                hready,
   input  wire logic                hreadyout,
   input  wire logic                hresp,
   input  wire logic                core_reset,
   input  wire logic                pc_clear,
   input  wire logic                sp_load_top,
   input  wire logic                sp_clear,
   input  wire logic [N_INTS-1:0]   int_enable,
   input  wire logic [N_TIMERS-1:0] timer_enable,
   input  wire logic [N_PINS-1:0]   port_dir_input,
   input  wire logic                timeout_flag,
   input  wire logic                power_down_flag,
   input  wire logic                low_voltage_reset_flag
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_release;
      $fell(core_reset);
   endsequence

   sequence s_full_state;
      int_enable == '0 && timer_enable == '0 && port_dir_input == '1;
   endsequence

   a_release_pc: assert property (s_release |-> pc_clear)
      else $error("pc_clear missing at reset release");
   a_pc_single: assert property (pc_clear |-> !core_reset && $past(core_reset) ##1 !pc_clear)
      else $error("pc_clear not a single pulse at release");
   a_sp_kind: assert property ((sp_load_top || sp_clear) |-> pc_clear && !(sp_load_top && sp_clear))
      else $error("stack pointer pulse without matching reset");
   a_full_state: assert property (sp_load_top |-> ##[0:1] s_full_state)
      else $error("full reset left enables or directions set");
   a_sleep_flags: assert property (sp_clear |-> ##[0:1] (timeout_flag && power_down_flag))
      else $error("sleep watchdog reset did not set both flags");
   a_timeout_moment: assert property ($changed(timeout_flag) |-> pc_clear && timeout_flag)
      else $error("timeout flag changed outside a watchdog reset");
   a_lvr_hw_only: assert property ($rose(low_voltage_reset_flag) |-> core_reset || pc_clear)
      else $error("low voltage flag set outside a reset");
   a_read_wait: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read did not take exactly one wait state");
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("slave response not OKAY");
endmodule

bind rsflg_top rsflg_top_sva #(.N_TIMERS(N_TIMERS), .N_PINS(N_PINS), .N_INTS(N_INTS)) rsflg_top_sva_i
(
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .core_reset(core_reset),
   .pc_clear(pc_clear), .sp_load_top(sp_load_top), .sp_clear(sp_clear),
   .int_enable(int_enable), .timer_enable(timer_enable), .port_dir_input(port_dir_input),
   .timeout_flag(timeout_flag), .power_down_flag(power_down_flag),
   .low_voltage_reset_flag(low_voltage_reset_flag)
);

`default_nettype wire

/* tb/rsflg_bench.sv */
// Self-checking bench for the reset state and flag logic.
`timescale 1ns/1ps
`default_nettype none
`include "rsflg_params.svh"

module rsflg_bench
   import rsflg_pkg::*;
;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
   logic        ext_reset_n_pin = 1, supply_monitor_reset = 0, halt_entry = 0, irq;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, r, v;
   logic [1:0]  htrans = 0, fl;
   logic [2:0]  hsize = 3'h2;
   logic        core_reset, pc_clear, sp_load_top, sp_clear, lv, full;
   logic        timeout_flag, power_down_flag, low_voltage_reset_flag;
   logic [7:0]  int_enable, port_dir_input;
   logic [1:0]  timer_enable;
   rsflg_mode_t cpu_mode = RSFLG_MODE_NORMAL;
   int          mismatches = 0, checks = 0, cycles = 0, seed;
   int          n_pc = 0, n_top = 0, n_clr = 0, e_pc = 0, e_top = 0, e_clr = 0;
   int          kinds [6] = '{2, 2, 2, 0, 0, 1};
   rsflg_mode_t modes [6] = '{RSFLG_MODE_SLOW, RSFLG_MODE_SLEEP, RSFLG_MODE_IDLE,
                              RSFLG_MODE_NORMAL, RSFLG_MODE_SLOW, RSFLG_MODE_NORMAL};

   // A short watchdog keeps each time-out scenario to a few dozen cycles.
   rsflg_top #(.WDT_TIMEOUT(16'h0010)) rsflg_top_i
   (
      .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .ext_reset_n_pin(ext_reset_n_pin), .supply_monitor_reset(supply_monitor_reset),
      .cpu_mode(cpu_mode), .halt_entry(halt_entry), .core_reset(core_reset),
      .pc_clear(pc_clear), .sp_load_top(sp_load_top), .sp_clear(sp_clear),
      .int_enable(int_enable), .timer_enable(timer_enable), .port_dir_input(port_dir_input),
      .timeout_flag(timeout_flag), .power_down_flag(power_down_flag),
      .low_voltage_reset_flag(low_voltage_reset_flag), .irq(irq)
   );

   always #5 hclk = ~hclk;
   always @(posedge pc_clear) n_pc++;
   always @(posedge sp_load_top) n_top++;
   always @(posedge sp_clear) n_clr++;

   task automatic summarize();
      if (mismatches == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   always @(posedge hclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         mismatches++;
         summarize();
      end
   end

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [2:0] sz, output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= sz;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   // Flags are packed {power_down, timeout}; kinds are 0 supply, 1 pin, 2 watchdog.
   function automatic logic [1:0] exp_flags(input int k, input rsflg_mode_t m,
                                            input logic [1:0] old);
      if (k == 2 && m inside {RSFLG_MODE_IDLE, RSFLG_MODE_SLEEP})
         return 2'h3;
      if (k == 2)
         return {old[1], 1'b1};
      return old;
   endfunction

   function automatic logic [3:0] exp_cause(input int k);
      return 4'h2 << k;
   endfunction

   task automatic settle();
      wait (core_reset === 1'b1);
      wait (core_reset === 1'b0);
      @(negedge hclk);
   endtask

   // The watchdog is read and stopped first, before it can fire again.
   task automatic expect_state(input logic [1:0] f, input logic fu, input logic [31:0] val,
                               input logic [3:0] cause, input logic l);
      bus(1'b0, `RSFLG_OFS_WDT_CTRL, 32'h0, 3'h2, r);
      chk("wdt_enable", 32'h1, 32'(r[0]));
      bus(1'b0, `RSFLG_OFS_WDT_COUNT, 32'h0, 3'h2, r);
      chk("wdt_counting", 32'h1, 32'(r != 32'h0 && r < 32'h10));
      bus(1'b1, `RSFLG_OFS_WDT_CTRL, 32'h0, 3'h2, r);
      e_pc++;
      e_top += fu;
      e_clr += !fu;
      chk("pc_pulses", 32'(e_pc), 32'(n_pc));
      chk("sp_top_pulses", 32'(e_top), 32'(n_top));
      chk("sp_clear_pulses", 32'(e_clr), 32'(n_clr));
      chk("flags", 32'(f), 32'({power_down_flag, timeout_flag}));
      chk("int_enable", fu ? 32'h0 : 32'(val[7:0]), 32'(int_enable));
      chk("timer_enable", fu ? 32'h0 : 32'(val[1:0]), 32'(timer_enable));
      chk("port_dir", fu ? 32'hFF : 32'(val[7:0]), 32'(port_dir_input));
      chk("lvr_flag", 32'(l), 32'(low_voltage_reset_flag));
      bus(1'b0, `RSFLG_OFS_STATUS, 32'h0, 3'h2, r);
      chk("status", 32'({1'b0, cause, 1'b0, l, f}), r);
   endtask

   initial
   begin
      seed = 26809;
      fl = 2'h0;
      lv = 1'b0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      settle();
      expect_state(fl, 1'b1, 32'h0, `RSFLG_CAUSE_POR, lv);
      for (int i = 0; i < 6; i++)
      begin
         v = $random(seed);
         bus(1'b1, `RSFLG_OFS_INT_EN, v, 3'h2, r);
         bus(1'b1, `RSFLG_OFS_TIMER_EN, v, 3'h2, r);
         bus(1'b1, `RSFLG_OFS_PORT_DIR, v, 3'h2, r);
         @(posedge hclk);
         cpu_mode <= modes[i];
         if (kinds[i] == 2)
            bus(1'b1, `RSFLG_OFS_WDT_CTRL, 32'h1, 3'h2, r);
         else
         begin
            supply_monitor_reset <= (kinds[i] == 0);
            ext_reset_n_pin <= (kinds[i] != 1);
            repeat (4) @(posedge hclk);
            supply_monitor_reset <= 1'b0;
            ext_reset_n_pin <= 1'b1;
         end
         settle();
         fl = exp_flags(kinds[i], modes[i], fl);
         lv = lv | (kinds[i] == 0);
         full = !(kinds[i] == 2 && modes[i] inside {RSFLG_MODE_IDLE, RSFLG_MODE_SLEEP});
         expect_state(fl, full, v, exp_cause(kinds[i]), lv);
         @(posedge hclk);
         cpu_mode <= RSFLG_MODE_NORMAL;
      end
      // A supply dip during sleep must not reset the core.
      @(posedge hclk);
      cpu_mode <= RSFLG_MODE_SLEEP;
      supply_monitor_reset <= 1'b1;
      repeat (8) @(posedge hclk);
      chk("sleep_lvr_core_reset", 32'h0, 32'(core_reset));
      supply_monitor_reset <= 1'b0;
      repeat (4) @(posedge hclk);
      cpu_mode <= RSFLG_MODE_NORMAL;
      bus(1'b1, `RSFLG_OFS_STATUS, 32'h4, 3'h2, r);
      bus(1'b1, `RSFLG_OFS_STATUS, 32'h4, 3'h2, r);
      chk("lvr_flag_clear", 32'h0, 32'(low_voltage_reset_flag));
      // The last pin reset cleared the enables, so the word value is written again first.
      bus(1'b1, `RSFLG_OFS_INT_EN, v, 3'h2, r);
      bus(1'b1, `RSFLG_OFS_INT_EN, ~v, 3'h0, r);
      bus(1'b0, `RSFLG_OFS_INT_EN, 32'h0, 3'h2, r);
      chk("byte_write_ignored", 32'(v[7:0]), r);
      bus(1'b0, 8'h20, 32'h0, 3'h2, r);
      chk("unmapped", 32'h0, r);
      chk("irq_masked", 32'h0, 32'(irq));
      bus(1'b0, `RSFLG_OFS_IRQ_STAT, 32'h0, 3'h2, r);
      chk("irq_stat", 32'hF, r);
      bus(1'b1, `RSFLG_OFS_IRQ_MASK, 32'hF, 3'h2, r);
      repeat (2) @(posedge hclk);
      chk("irq_on", 32'h1, 32'(irq));
      bus(1'b1, `RSFLG_OFS_IRQ_STAT, 32'hF, 3'h2, r);
      bus(1'b0, `RSFLG_OFS_IRQ_STAT, 32'h0, 3'h2, r);
      chk("irq_stat_clear", 32'h0, r);
      chk("irq_off", 32'h0, 32'(irq));
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      fl = 2'h0;
      settle();
      expect_state(fl, 1'b1, 32'h0, `RSFLG_CAUSE_POR, 1'b0);
      @(posedge hclk);
      halt_entry <= 1'b1;
      @(posedge hclk);
      halt_entry <= 1'b0;
      repeat (2) @(posedge hclk);
      chk("halt_power_down", 32'h1, 32'(power_down_flag));
      summarize();
   end
endmodule

`default_nettype wire
